/* verilog/nsu_serial_unit.sv */
// clocked serial unit with nibble buffer, avalon register slave
// Operation
// R1: software sets enable, polls end flag, clears
// R2: one-word reception raises buffer interrupt once
// R3: software selects mode, loads data, then enables
// R4: drive out on leading, sample on trailing
// R5: full shift register moves to buffer, interrupts
// R6: first buffer access low nibble, next high
// R7: internal clock stops until buffer serviced
// R8: external clock: software services before next shift
// R9: software writes transmit data after reading all
// R10: enable cleared: finish current word, then end
// R11: active flag status bit 3 clears at end
// R12: command two 0110B/1110B select mode, start
// R13: force-stop bit 3 aborts transfer
// R14: forced stop resets shift counter
// R15: force-stop self clears, other bits untouched
// R16: forced stop sets clock and data high (data only in transmit modes here)
// R17: resumed data pin holds prior bit first
// R18: shift end flag is status bit 2
// R19: mode change discards buffer contents
// R20: serial data leaves least significant bit first
// R21: interrupt withdrawn once buffer accesses done
`timescale 1ns/10ps
`default_nettype none

module nsu_serial_unit (
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	// avalon-mm slave
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// serial pins
	input  wire logic        sck_in,
	output logic             sck_out,
	output logic             sck_oe_n,
	output logic             so_out,
	input  wire logic        si_in,
	// buffer event
	output logic             serial_buffer_irq
);

	// -----------------------------------------------------------------
	// state
	// -----------------------------------------------------------------
	nsu_pkg::nsu_state_e state;
	nsu_pkg::nsu_state_e next_state;
	logic [3:0]  command_reg_one;
	logic [3:0]  command_reg_two;
	logic [7:0]  shift;
	logic [2:0]  bit_cnt;
	logic [10:0] div_cnt;
	logic        nib_ptr;
	logic        next_ptr;
	logic        rx_unread;
	logic        tx_full;
	logic        word_pend;
	logic        shift_end_flag;
	logic        transfer_active_flag;
	logic        resume_pend;
	logic        so_saved;
	logic        sck_s1, sck_s2, sck_s3, sck_lvl;
	logic        si_s1, si_s2, si_s3, si_lvl;
	logic [3:0]  mem_rd;
	logic [7:0]  mem_word;

	// -----------------------------------------------------------------
	// bus decode
	// -----------------------------------------------------------------
	wire req      = avs_read | avs_write;
	wire acc      = req & ~avs_waitrequest;
	wire wr_acc   = acc & avs_write & avs_byteenable[0];
	wire rd_acc   = acc & avs_read;
	wire sel_cmd1 = avs_address == nsu_pkg::REG_CMD1;
	wire sel_cmd2 = avs_address == nsu_pkg::REG_CMD2;
	wire sel_stat = avs_address == nsu_pkg::REG_STAT;
	wire sel_buf  = avs_address == nsu_pkg::REG_BUF;
	wire wr_cmd1  = wr_acc & sel_cmd1;
	wire wr_cmd2  = wr_acc & sel_cmd2;
	wire wr_buf   = wr_acc & sel_buf;
	wire rd_buf   = rd_acc & sel_buf;

	// mode fields
	// R12: mode and enable decode
	wire [1:0] mode     = command_reg_two[nsu_pkg::C2_MODE_HI:nsu_pkg::C2_MODE_LO];
	wire [1:0] new_mode = avs_writedata[nsu_pkg::C2_MODE_HI:nsu_pkg::C2_MODE_LO];
	wire tx_mode  = (mode == nsu_pkg::MODE_TX) | (mode == nsu_pkg::MODE_TXRX);
	wire rx_mode  = (mode == nsu_pkg::MODE_RX) | (mode == nsu_pkg::MODE_TXRX);
	wire word8    = mode == nsu_pkg::MODE_TXRX;
	wire ext_clk  = command_reg_two[nsu_pkg::C2_EXT_CLK_BIT];
	wire serial_enable_bit = command_reg_two[nsu_pkg::C2_ENABLE_BIT];
	wire force_stop_bit    = command_reg_one[nsu_pkg::C1_FORCE_STOP_BIT];
	wire [2:0] rate = command_reg_one[nsu_pkg::C1_RATE_HI:nsu_pkg::C1_RATE_LO];
	// R19: a new mode discards the buffer
	wire mode_chg = wr_cmd2 & (new_mode != mode);

	// buffer access accounting
	// R6: second access closes an 8-bit word
	wire last_acc   = ~word8 | nib_ptr;
	wire buf_wr     = wr_buf & tx_mode;
	wire tx_done_wr = buf_wr & last_acc;
	wire rx_done_rd = rd_buf & last_acc;

	// -----------------------------------------------------------------
	// serial clock edges
	// -----------------------------------------------------------------
	wire st_idle   = state == nsu_pkg::ST_IDLE;
	wire st_shift  = state == nsu_pkg::ST_SHIFT;
	wire st_wait   = state == nsu_pkg::ST_WAIT;
	wire ext_chg   = (sck_s2 == sck_s3) & (sck_s3 != sck_lvl);
	wire ext_lead  = ext_chg & ~sck_s3;
	wire ext_trail = ext_chg & sck_s3;
	wire div_hit   = st_shift & (div_cnt == 11'h000);
	wire [10:0] half_cyc = nsu_pkg::SCK_HALF_CYC << rate;
	wire lead      = ext_clk ? ext_lead : (div_hit & sck_out);
	wire trail     = ext_clk ? ext_trail : (div_hit & ~sck_out);
	wire last_bit  = bit_cnt == (word8 ? nsu_pkg::LAST_BIT_8 : nsu_pkg::LAST_BIT_4);
	wire word_done = st_shift & trail & last_bit;

	// data level once stages two and three agree, no extra cycle of lag
	wire si_bit = (si_s2 == si_s3) ? si_s3 : si_lvl;

	// received bit enters at the top of the active word
	wire [7:0] shift_r  = {1'b0, shift[7:1]};
	wire [7:0] shift_in = word8 ? {si_bit, shift_r[6:0]} :
		{shift_r[7:4], si_bit, shift_r[2:0]};

	// -----------------------------------------------------------------
	// sequencing terms
	// -----------------------------------------------------------------
	// R13: force-stop aborts a running transfer
	wire abort     = force_stop_bit & ~st_idle;
	wire tx_ready  = ~tx_mode | tx_full;
	// R7: internal clock waits for the unread word
	wire pend_go   = word_pend & (~rx_unread | ext_clk);
	wire rx_load   = st_wait & pend_go;
	// R7: internal clock waits for fresh transmit data
	wire wait_go   = st_wait & ~word_pend & serial_enable_bit &
		(ext_clk ? ext_lead : tx_ready);
	// R10: leave only after the word reached the buffer
	wire wait_end  = st_wait & ~word_pend & ~serial_enable_bit;
	// R17: resume reuses kept shift word
	wire start     = st_idle & serial_enable_bit & ~force_stop_bit &
		(tx_ready | resume_pend);
	wire load_shift = (start | wait_go) & tx_mode & tx_full;
	// R5: buffer full and transmit-empty requests
	wire irq_set   = rx_load | (load_shift & ~rx_mode);
	// R21: withdraw once reads or writes are done
	wire irq_clr   = (rx_done_rd & ~tx_mode) | tx_done_wr | mode_chg;
	wire [7:0] load_word = load_shift ? mem_word : shift;

	// nibble pointer selection
	// R6: pointer restarts at mode setting or interrupt
	assign next_ptr = (irq_set | wr_cmd2) ? 1'b0 :
		((buf_wr | rd_buf) & word8) ? ~nib_ptr : nib_ptr;

	// read mux
	wire [3:0] stat_val = {transfer_active_flag, shift_end_flag, serial_buffer_irq, rx_unread};
	wire [31:0] rd_mux = sel_cmd1 ? {28'h0000000, command_reg_one} :
		sel_cmd2 ? {28'h0000000, command_reg_two} :
		sel_stat ? {28'h0000000, stat_val} :
		sel_buf  ? {28'h0000000, mem_rd} : 32'h00000000;

	// -----------------------------------------------------------------
	// shared buffer
	// -----------------------------------------------------------------
	nsu_nib_mem u_buf (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.wr_en    (buf_wr),
		.wr_addr  (nib_ptr),
		.wr_data  (avs_writedata[3:0]),
		.ld_en    (rx_load),
		.ld_data  (shift),
		.rd_addr  (next_ptr),
		.rd_data  (mem_rd),
		.word     (mem_word)
	);

	// -----------------------------------------------------------------
	// next state
	// -----------------------------------------------------------------
	always_comb begin
		next_state = state;
		case (state)
			nsu_pkg::ST_IDLE: begin
				if (start)
					next_state = nsu_pkg::ST_SHIFT;
			end
			nsu_pkg::ST_SHIFT: begin
				if (word_done)
					next_state = nsu_pkg::ST_WAIT;
			end
			nsu_pkg::ST_WAIT: begin
				if (wait_end)
					next_state = nsu_pkg::ST_IDLE;
				else if (wait_go)
					next_state = nsu_pkg::ST_SHIFT;
			end
			default: next_state = nsu_pkg::ST_IDLE;
		endcase
		if (abort)
			next_state = nsu_pkg::ST_IDLE;
	end

	// input synchronisers, filtered level after agreement
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			{sck_s1, sck_s2, sck_s3, sck_lvl} <= 4'hF;
			{si_s1, si_s2, si_s3, si_lvl}     <= 4'hF;
		end else begin
			{sck_s1, sck_s2, sck_s3} <= {sck_in, sck_s1, sck_s2};
			{si_s1, si_s2, si_s3}    <= {si_in, si_s1, si_s2};
			if (sck_s2 == sck_s3)
				sck_lvl <= sck_s3;
			if (si_s2 == si_s3)
				si_lvl <= si_s3;
		end
	end

	// avalon handshake: one wait cycle, effects at the accept edge
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h00000000;
		end else begin
			avs_waitrequest <= ~(req & avs_waitrequest);
			if (avs_read & avs_waitrequest)
				avs_readdata <= rd_mux;
		end
	end

	// command registers
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			command_reg_one <= nsu_pkg::CMD1_RST;
			command_reg_two <= nsu_pkg::CMD2_RST;
		end else begin
			if (wr_cmd1)
				command_reg_one <= avs_writedata[3:0];
			// R15: force-stop self clears once stopped
			else if (force_stop_bit & st_idle)
				command_reg_one[nsu_pkg::C1_FORCE_STOP_BIT] <= 1'b0;
			if (wr_cmd2)
				command_reg_two <= avs_writedata[3:0];
		end
	end

	// buffer bookkeeping flags, set wins over clear
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			nib_ptr           <= 1'b0;
			rx_unread         <= 1'b0;
			tx_full           <= 1'b0;
			serial_buffer_irq <= 1'b0;
		end else begin
			nib_ptr           <= next_ptr;
			rx_unread         <= rx_load | (rx_unread & ~(rx_done_rd | mode_chg));
			tx_full           <= tx_done_wr | (tx_full & ~(load_shift | mode_chg));
			// R2: one raise per delivered word
			serial_buffer_irq <= irq_set | (serial_buffer_irq & ~irq_clr);
		end
	end

	// transfer engine
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state                <= nsu_pkg::ST_IDLE;
			transfer_active_flag <= 1'b0;
			word_pend            <= 1'b0;
			shift_end_flag       <= 1'b0;
		end else begin
			state                <= next_state;
			// R11: active flag follows the engine
			transfer_active_flag <= next_state != nsu_pkg::ST_IDLE;
			word_pend <= (word_done & rx_mode) | (word_pend & ~(rx_load | abort));
			// R18: shift end flag marks a finished word
			shift_end_flag <= word_done | (shift_end_flag & ~(start | wait_go));
		end
	end

	// shift register and bit counter
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			shift   <= 8'h00;
			bit_cnt <= 3'h0;
		end else begin
			// R5: receive bits gather in the shift register
			if (load_shift)
				shift <= mem_word;
			else if (st_shift & trail)
				shift <= shift_in;
			// R14: counter back to its start
			if (abort | start | wait_go)
				bit_cnt <= 3'h0;
			else if (st_shift & trail)
				bit_cnt <= last_bit ? 3'h0 : bit_cnt + 3'h1;
		end
	end

	// internal serial clock, held high outside shifting
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			div_cnt  <= 11'h000;
			sck_out  <= 1'b1;
			sck_oe_n <= 1'b1;
		end else begin
			sck_oe_n <= ext_clk;
			// R16: clock stops high on abort or wait
			if (!st_shift | ext_clk | abort) begin
				div_cnt <= half_cyc - 11'h001;
				sck_out <= 1'b1;
			end else if (div_hit) begin
				div_cnt <= half_cyc - 11'h001;
				sck_out <= ~sck_out;
			end else begin
				div_cnt <= div_cnt - 11'h001;
			end
		end
	end

	// serial data out
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			so_out      <= 1'b1;
			so_saved    <= 1'b1;
			resume_pend <= 1'b0;
		end else begin
			// R16: data pin high on abort in transmit modes, remember bit
			if (abort & tx_mode) begin
				so_out      <= 1'b1;
				so_saved    <= so_out;
				resume_pend <= 1'b1;
			// R17: resumed pin shows the held bit
			end else if (start & resume_pend) begin
				so_out      <= so_saved;
				resume_pend <= 1'b0;
			// R4: drive on the leading edge
			// R20: lowest bit leaves first
			end else if (st_shift & lead & tx_mode) begin
				so_out <= shift[0];
			end else if (wait_go & ext_clk & tx_mode) begin
				so_out <= load_word[0];
			end
		end
	end

	// -----------------------------------------------------------------
	// assertions
	// -----------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	property p_rx_irq;
		rx_load |=> serial_buffer_irq && rx_unread && !nib_ptr;
	endproperty
	a_rx_irq: assert property (p_rx_irq) else $error("no interrupt after word load"); // R5

	property p_stop_count;
		abort |=> (bit_cnt == 3'h0) && (state == nsu_pkg::ST_IDLE);
	endproperty
	a_stop_count: assert property (p_stop_count) else $error("abort left counter or state"); // R14

	property p_stop_pins;
		abort && tx_mode |=> sck_out && so_out;
	endproperty
	a_stop_pins: assert property (p_stop_pins) else $error("pins not high after abort"); // R16

	property p_force_clr;
		force_stop_bit && st_idle && !wr_cmd1 |=>
			!force_stop_bit && (rate == $past(rate));
	endproperty
	a_force_clr: assert property (p_force_clr) else $error("force-stop not self cleared"); // R15

	property p_active_low;
		st_idle && !start |=> !transfer_active_flag ##1 (transfer_active_flag == !st_idle);
	endproperty
	a_active_low: assert property (p_active_low) else $error("active flag wrong when idle"); // R11

	property p_ptr_irq;
		$rose(serial_buffer_irq) |-> !nib_ptr;
	endproperty
	a_ptr_irq: assert property (p_ptr_irq) else $error("pointer not at low nibble"); // R6

	property p_wait_stop;
		st_wait && !ext_clk |=> sck_out;
	endproperty
	a_wait_stop: assert property (p_wait_stop) else $error("clock runs during wait"); // R7

	property p_lsb;
		st_shift && lead && tx_mode && !abort |=> so_out == $past(shift[0]);
	endproperty
	a_lsb: assert property (p_lsb) else $error("wrong bit on data out"); // R4

	property p_end_flush;
		$fell(transfer_active_flag) && !$past(force_stop_bit, 2) |-> !word_pend;
	endproperty
	a_end_flush: assert property (p_end_flush) else $error("ended before word delivered"); // R10

	property p_irq_clr;
		tx_done_wr && !irq_set |=> !serial_buffer_irq;
	endproperty
	a_irq_clr: assert property (p_irq_clr) else $error("interrupt not withdrawn"); // R21

	c_rx_load: cover property (rx_load);
	c_txrx_fill: cover property (word8 && tx_done_wr);
	c_abort: cover property (abort && tx_mode);
	c_wait_int: cover property (st_wait && !ext_clk ##1 st_wait);

endmodule

`default_nettype wire

/* verilog/nsu_pkg.sv */
// constants and types of the nibble serial unit
package nsu_pkg;

	// -----------------------------------------------------------------
	// register byte addresses
	// -----------------------------------------------------------------
	localparam int          ADDR_W       = 4;
	localparam logic [3:0]  REG_CMD1     = 4'h0;
	localparam logic [3:0]  REG_CMD2     = 4'h4;
	localparam logic [3:0]  REG_STAT     = 4'h8;
	localparam logic [3:0]  REG_BUF      = 4'hC;

	// -----------------------------------------------------------------
	// widths
	// -----------------------------------------------------------------
	localparam int          NIB_W        = 4;
	localparam int          WORD_W       = 8;
	localparam int          DIV_W        = 11;

	// -----------------------------------------------------------------
	// command register one fields
	// -----------------------------------------------------------------
	localparam int          C1_FORCE_STOP_BIT = 3;
	localparam int          C1_RATE_HI        = 2;
	localparam int          C1_RATE_LO        = 0;
	localparam logic [3:0]  CMD1_RST          = 4'h0;

	// -----------------------------------------------------------------
	// command register two fields and mode codes
	// -----------------------------------------------------------------
	localparam int          C2_ENABLE_BIT  = 3;
	localparam int          C2_MODE_HI     = 2;
	localparam int          C2_MODE_LO     = 1;
	localparam int          C2_EXT_CLK_BIT = 0;
	localparam logic [3:0]  CMD2_RST       = 4'h0;
	localparam logic [1:0]  MODE_TX        = 2'h1;
	localparam logic [1:0]  MODE_RX        = 2'h2;
	localparam logic [1:0]  MODE_TXRX      = 2'h3;

	// -----------------------------------------------------------------
	// status register fields
	// -----------------------------------------------------------------
	localparam int          ST_ACTIVE_BIT  = 3;
	localparam int          ST_SEF_BIT     = 2;
	localparam int          ST_IRQ_BIT     = 1;
	localparam int          ST_RXFULL_BIT  = 0;

	// -----------------------------------------------------------------
	// bit counts per word
	// -----------------------------------------------------------------
	localparam logic [2:0]  LAST_BIT_4     = 3'h3;
	localparam logic [2:0]  LAST_BIT_8     = 3'h7;

	// -----------------------------------------------------------------
	// internal serial clock timing
	// -----------------------------------------------------------------
	localparam int          CLK_PERIOD_NS    = 8;
	localparam int          SCK_HALF_BASE_NS = 32;
	localparam logic [DIV_W-1:0] SCK_HALF_CYC =
		DIV_W'((SCK_HALF_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// -----------------------------------------------------------------
	// transfer engine states
	// -----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_SHIFT = 3'b010,
		ST_WAIT  = 3'b100
	} nsu_state_e;

endpackage

/* verilog/nsu_nib_mem.sv */
// two-nibble shared transmit and receive buffer
`timescale 1ns/10ps
`default_nettype none

module nsu_nib_mem (
	// clock and reset
	input  wire logic                        core_clk,
	input  wire logic                        rst_n,
	// nibble write port
	input  wire logic                        wr_en,
	input  wire logic                        wr_addr,
	input  wire logic [nsu_pkg::NIB_W-1:0]   wr_data,
	// whole word load port
	input  wire logic                        ld_en,
	input  wire logic [nsu_pkg::WORD_W-1:0]  ld_data,
	// nibble read port and whole word
	input  wire logic                        rd_addr,
	output logic      [nsu_pkg::NIB_W-1:0]   rd_data,
	output logic      [nsu_pkg::WORD_W-1:0]  word
);

	logic [nsu_pkg::WORD_W-1:0] next_word;

	// per-nibble next content, word load beats nibble write
	genvar i;
	generate
		for (i = 0; i < 2; i = i + 1) begin : g_nib
			assign next_word[i*4 +: 4] = ld_en ? ld_data[i*4 +: 4] :
				(wr_en && (wr_addr == 1'(i))) ? wr_data : word[i*4 +: 4];
		end
	endgenerate

	// storage and registered read, forwarding same-edge updates
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			word    <= 8'h00;
			rd_data <= 4'h0;
		end else begin
			word    <= next_word;
			rd_data <= rd_addr ? next_word[7:4] : next_word[3:0];
		end
	end

endmodule

`default_nettype wire

/* sim/nsu_partner.sv */
// serial partner model: shifts one word in and out, lsb first
`timescale 1ns/10ps
`default_nettype none

module nsu_partner (
	// serial line
	input  wire logic       sck_line,
	input  wire logic       so_out,
	output logic            si_in,
	output logic            sck_drv,
	// observed traffic
	output logic [7:0]      rx_word,
	output logic [7:0]      bit_cnt
);
	logic [7:0] tx_sh;

	// idle line levels
	initial begin
		si_in = 1'b1;
		sck_drv = 1'b1;
		rx_word = 8'h00;
		bit_cnt = 8'h00;
		tx_sh = 8'h00;
	end

	always @(negedge sck_line) begin
		si_in <= tx_sh[0];
		tx_sh <= {tx_sh[0], tx_sh[7:1]};
	end

	always @(posedge sck_line) begin
		rx_word <= {so_out, rx_word[7:1]};
		bit_cnt <= bit_cnt + 8'h01;
	end

	// loads the word to send and clears the bit count
	task automatic load(input logic [7:0] w);
		tx_sh = w;
		bit_cnt = 8'h00;
	endtask

	// external clock bursts, idle high outside the frame
	task automatic run_clock(input int n);
		#3;
		repeat (n) begin
			#32 sck_drv = 1'b0;
			#32 sck_drv = 1'b1;
		end
	endtask
endmodule

`default_nettype wire

/* sim/nsu_serial_unit_tb_top.sv */
// self-checking bench of the nibble serial unit
`timescale 1ns/10ps
`default_nettype none

module nsu_serial_unit_tb_top;
	logic        core_clk;
	logic        rst_n;
	logic [3:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        sck_out;
	logic        sck_oe_n;
	logic        so_out;
	logic        si_in;
	logic        sck_drv;
	logic        serial_buffer_irq;
	wire logic   sck_line;
	logic [7:0]  rx_word;
	logic [7:0]  bit_cnt;
	logic [31:0] rd_q;
	logic        irq_q;
	int          irq_rises;
	int          error_cnt;
	int          samples_checked;

	// -----------------------------------------------------------------
	// design, partner and clock
	// -----------------------------------------------------------------
	assign sck_line = sck_oe_n ? sck_drv : sck_out;

	nsu_serial_unit nsu_serial_unit_i (
		.core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hF), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .sck_in(sck_line), .sck_out(sck_out),
		.sck_oe_n(sck_oe_n), .so_out(so_out), .si_in(si_in),
		.serial_buffer_irq(serial_buffer_irq)
	);

	nsu_partner nsu_partner_i (
		.sck_line(sck_line), .so_out(so_out), .si_in(si_in), .sck_drv(sck_drv),
		.rx_word(rx_word), .bit_cnt(bit_cnt)
	);

	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	// counts buffer interrupt rises
	always @(posedge core_clk) begin
		irq_q <= serial_buffer_irq;
		if (serial_buffer_irq === 1'b1 && irq_q === 1'b0) irq_rises <= irq_rises + 1;
	end

	// -----------------------------------------------------------------
	// tasks
	// -----------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic stop_test();
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// one avalon access, held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [3:0] a, input logic [3:0] d);
		int n;
		n = 0;
		avs_address <= a;
		avs_write <= wr;
		avs_read <= ~wr;
		avs_writedata <= {28'h0000000, d};
		do begin
			@(posedge core_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 40);
		rd_q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		if (n >= 40) begin
			check(32'h1, 32'h0);
			stop_test();
		end
		@(posedge core_clk);
	endtask

	task automatic rdc(input logic [3:0] a, input logic [3:0] e);
		bus(1'b0, a, 4'h0);
		check(rd_q, {28'h0000000, e});
	endtask

	// polls one status bit under a bound
	task automatic wait_stat(input int b, input logic v);
		int n;
		n = 0;
		do begin
			bus(1'b0, nsu_pkg::REG_STAT, 4'h0);
			n++;
		end while (rd_q[b] !== v && n < 400);
		if (n >= 400) begin
			check(32'h1, 32'h0);
			stop_test();
		end
	endtask

	// -----------------------------------------------------------------
	// main sequence
	// -----------------------------------------------------------------
	initial begin
		rst_n = 1'b0;
		avs_address = 4'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h00000000;
		irq_rises = 0;
		error_cnt = 0;
		samples_checked = 0;
		repeat (20) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		rdc(nsu_pkg::REG_STAT, 4'h0);
		rdc(4'h2, 4'h0);
		$display("reset test done");
		nsu_partner_i.load(8'hA5);
		// full duplex word, wait state, then end after next word
		bus(1'b1, nsu_pkg::REG_CMD1, 4'h0);
		bus(1'b1, nsu_pkg::REG_CMD2, 4'h6);
		bus(1'b1, nsu_pkg::REG_BUF, 4'h3);
		bus(1'b1, nsu_pkg::REG_BUF, 4'hC);
		bus(1'b1, nsu_pkg::REG_CMD2, 4'hE);
		wait_stat(nsu_pkg::ST_IRQ_BIT, 1'b1);
		check(32'(rx_word), 32'hC3);
		rdc(nsu_pkg::REG_STAT, 4'hF);
		rdc(nsu_pkg::REG_BUF, 4'h5);
		rdc(nsu_pkg::REG_BUF, 4'hA);
		repeat (40) @(posedge core_clk);
		check(32'(bit_cnt), 32'h8);
		check(32'(sck_out), 32'h1);
		bus(1'b1, nsu_pkg::REG_BUF, 4'h1);
		bus(1'b1, nsu_pkg::REG_BUF, 4'h8);
		repeat (2) @(posedge core_clk);
		check(32'(serial_buffer_irq), 32'h0);
		bus(1'b1, nsu_pkg::REG_CMD2, 4'h6);
		wait_stat(nsu_pkg::ST_ACTIVE_BIT, 1'b0);
		check(32'(rx_word), 32'h81);
		check(32'(serial_buffer_irq), 32'h1);
		rdc(nsu_pkg::REG_BUF, 4'h5);
		rdc(nsu_pkg::REG_BUF, 4'hA);
		$display("transfer test done");
		// forced stop in mid-word with enable left set
		bus(1'b1, nsu_pkg::REG_CMD2, 4'h6);
		bus(1'b1, nsu_pkg::REG_BUF, 4'hF);
		bus(1'b1, nsu_pkg::REG_BUF, 4'h0);
		bus(1'b1, nsu_pkg::REG_CMD2, 4'hE);
		repeat (20) @(posedge core_clk);
		bus(1'b1, nsu_pkg::REG_CMD1, 4'h9);
		repeat (2) @(posedge core_clk);
		check({30'h00000000, sck_out, so_out}, 32'h3);
		nsu_partner_i.load(8'h00);
		rdc(nsu_pkg::REG_CMD1, 4'h1);
		wait_stat(nsu_pkg::ST_IRQ_BIT, 1'b1);
		check(32'(bit_cnt), 32'h8);
		bus(1'b1, nsu_pkg::REG_CMD2, 4'h6);
		wait_stat(nsu_pkg::ST_ACTIVE_BIT, 1'b0);
		$display("stop test done");
		// one-word reception on the external clock
		bus(1'b1, nsu_pkg::REG_CMD1, 4'h0);
		bus(1'b1, nsu_pkg::REG_CMD2, 4'h5);
		bus(1'b0, nsu_pkg::REG_STAT, 4'h0);
		check(32'(rd_q[1:0]), 32'h0);
		check(32'(sck_oe_n), 32'h1);
		nsu_partner_i.load(8'h36);
		irq_rises = 0;
		bus(1'b1, nsu_pkg::REG_CMD2, 4'hD);
		fork
			nsu_partner_i.run_clock(4);
		join_none
		wait_stat(nsu_pkg::ST_SEF_BIT, 1'b1);
		bus(1'b1, nsu_pkg::REG_CMD2, 4'h5);
		wait_stat(nsu_pkg::ST_ACTIVE_BIT, 1'b0);
		check(32'(irq_rises), 32'h1);
		rdc(nsu_pkg::REG_BUF, 4'h6);
		repeat (2) @(posedge core_clk);
		check(32'(serial_buffer_irq), 32'h0);
		$display("reception test done");
		stop_test();
	end
endmodule

`default_nettype wire
